/* hdl/dtb_comparator.sv */
// Address comparator with optional read/write qualification.
`timescale 1ns/1ps
`default_nettype none
module dtb_comparator (
  input wire logic [7:0] high_byte,
  input wire logic [7:0] low_byte,
  input wire logic dir_enable,
  input wire logic dir_read,
  input wire dtb_pkg::dtb_bus_s bus,
  output logic match,
  output logic below,
  output logic above
);
  logic [15:0] ref_addr;
  logic dir_ok;
  assign ref_addr = {high_byte, low_byte};
  // A set direction enable bit means only cycles whose read flag equals dir_read qualify.
  assign dir_ok = !dir_enable || (bus.read == dir_read);
  assign match = bus.valid && dir_ok && (bus.addr == ref_addr);
  assign below = bus.valid && dir_ok && (bus.addr < ref_addr);
  assign above = bus.valid && dir_ok && (bus.addr > ref_addr);
endmodule
`default_nettype wire

/* hdl/dtb_debug_regs.sv */
// Debug module registers: comparators, trace FIFO, control and force reset.
//
// Functional notes
// - Force reset writable only from background commands.
// - Force reset register always reads zero.
// - Background write of bit 0 resets chip.
// - Comparator bytes reset zero, locked while armed.
// - FIFO high port read-only, zero in event modes.
// - FIFO high read does not advance.
// - FIFO low read advances; writes ignored.
// - Event modes store one byte per entry.
// - Low reads do not advance while armed.
// - Unarmed low read stores last opcode address.
// - Eight word FIFO; ninth read returns first.
// - Control register always readable and writable.
// - Module enable refused while chip secure.
// - Arm sets flag; run end or clear stops.
// - Bit 5 picks tag or force break.
// - Break enable raises CPU break requests.
// - Qualify select delays hits until the matched opcode executes.
// - Comparator A direction qualification.
// - Comparator B direction qualification.
// - Ten register bytes in normal memory.
// - Run ends on full or end trigger.
// - Modes 0011 and 0100 are event only.
`timescale 1ns/1ps
`default_nettype none
module dtb_debug_regs (
  input wire logic mclk,
  input wire logic reset,
  input wire logic secure,
  input wire dtb_pkg::dtb_access_s acc,
  input wire dtb_pkg::dtb_bus_s bus,
  input wire logic opcode_executed,
  output logic [7:0] rdata,
  output logic break_request,
  output logic break_is_tag,
  output logic force_mcu_reset,
  output logic run_active_flag
);
  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_WAIT_A = 2'b01,
    RUN_CAPTURE = 2'b11
  } dtb_run_e;

  typedef struct packed {
    logic [7:0] comp_a_high;
    logic [7:0] comp_a_low;
    logic [7:0] comp_b_high;
    logic [7:0] comp_b_low;
    logic [7:0] control;
    logic [7:0] trigger;
    logic flag_a;
    logic flag_b;
    logic [3:0] count;
    logic [2:0] rd_ptr;
    logic [2:0] wr_ptr;
    logic [dtb_pkg::FIFO_DEPTH-1:0][15:0] fifo;
    dtb_run_e run;
    logic [15:0] last_opcode;
    logic [7:0] rdata;
    logic brk;
    logic brk_tag;
    logic force_rst;
    logic run_flag;
  } dtb_state_s;

  dtb_state_s st_q;
  dtb_state_s st_d;

  // ==========================================================================
  // Comparators and trigger qualification
  // ==========================================================================
  logic raw_a, raw_b, lo_a, hi_b;
  logic trk_a, trk_b, hit_a, hit_b;

  dtb_comparator u_comp_a (
    .high_byte(st_q.comp_a_high),
    .low_byte(st_q.comp_a_low),
    .dir_enable(st_q.control[dtb_pkg::CTL_COMP_A_DIR_EN]),
    .dir_read(st_q.control[dtb_pkg::CTL_COMP_A_DIR]),
    .bus(bus),
    .match(raw_a),
    .below(lo_a),
    .above()
  );
  dtb_comparator u_comp_b (
    .high_byte(st_q.comp_b_high),
    .low_byte(st_q.comp_b_low),
    .dir_enable(st_q.control[dtb_pkg::CTL_COMP_B_DIR_EN]),
    .dir_read(st_q.control[dtb_pkg::CTL_COMP_B_DIR]),
    .bus(bus),
    .match(raw_b),
    .below(),
    .above(hi_b)
  );
  dtb_opcode_track u_track_a (
    .mclk(mclk),
    .reset(reset),
    .match_in(raw_a),
    .fetch(bus.opcode_fetch),
    .executed(opcode_executed),
    .hit(trk_a)
  );
  dtb_opcode_track u_track_b (
    .mclk(mclk),
    .reset(reset),
    .match_in(raw_b),
    .fetch(bus.opcode_fetch),
    .executed(opcode_executed),
    .hit(trk_b)
  );

  logic tag_sel, enabled, armed, event_mode, begin_trace, in_range, trig;
  logic [3:0] mode;
  assign tag_sel = st_q.trigger[dtb_pkg::TRG_QUALIFY_SELECT];
  assign hit_a = tag_sel ? trk_a : raw_a;
  assign hit_b = tag_sel ? trk_b : raw_b;
  assign enabled = st_q.control[dtb_pkg::CTL_MODULE_ENABLE];
  assign armed = st_q.control[dtb_pkg::CTL_ARM];
  assign mode = st_q.trigger[3:0];
  assign event_mode = (mode == dtb_pkg::MODE_EVENT_B) ||
                      (mode == dtb_pkg::MODE_A_THEN_EVENT_B);
  // Event-only runs are always begin traces.
  assign begin_trace = st_q.trigger[dtb_pkg::TRG_BEGIN] || event_mode;
  assign in_range = bus.valid && !lo_a && !hi_b;

  // Trigger for the current cycle, given the run state.
  always_comb begin
    unique case (mode)
      dtb_pkg::MODE_A_ONLY: trig = hit_a;
      dtb_pkg::MODE_A_OR_B: trig = hit_a || hit_b;
      dtb_pkg::MODE_A_THEN_B,
      dtb_pkg::MODE_A_THEN_EVENT_B: trig = (st_q.run == RUN_CAPTURE) ? hit_b : hit_a;
      dtb_pkg::MODE_EVENT_B: trig = hit_b;
      dtb_pkg::MODE_A_AND_B_DATA: trig = hit_a && (bus.data == st_q.comp_b_low);
      dtb_pkg::MODE_A_NOT_B_DATA: trig = hit_a && (bus.data != st_q.comp_b_low);
      dtb_pkg::MODE_INSIDE: trig = in_range;
      dtb_pkg::MODE_OUTSIDE: trig = bus.valid && (lo_a || hi_b);
      default: trig = 1'b0;
    endcase
  end

  // ==========================================================================
  // Register access and run control
  // ==========================================================================
  logic wr_user, rd_low, store, run_end;
  logic [15:0] store_word;
  logic [7:0] wctl;

  always_comb begin
    st_d = st_q;
    wr_user = acc.wr;
    rd_low = acc.rd && (acc.addr == dtb_pkg::OFF_FIFO_LOW);
    store = 1'b0;
    run_end = 1'b0;
    store_word = bus.addr;
    wctl = acc.wdata;
    st_d.brk = 1'b0;
    st_d.force_rst = 1'b0;
    if (bus.valid && bus.opcode_fetch) begin
      st_d.last_opcode = bus.addr;
    end

    // Capture side of an armed run.
    if (enabled && armed) begin
      if (raw_a) begin
        st_d.flag_a = 1'b1;
      end
      if (raw_b) begin
        st_d.flag_b = 1'b1;
      end
      if (event_mode) begin
        if (st_q.run == RUN_WAIT_A && mode == dtb_pkg::MODE_A_THEN_EVENT_B && hit_a) begin
          st_d.run = RUN_CAPTURE;
        end else if (st_q.run == RUN_CAPTURE && hit_b) begin
          store = 1'b1;
          store_word = {8'h00, bus.data};
        end
      end else if (begin_trace) begin
        if (st_q.run == RUN_WAIT_A && trig && mode != dtb_pkg::MODE_A_THEN_B) begin
          st_d.run = RUN_CAPTURE;
        end else if (st_q.run == RUN_WAIT_A && mode == dtb_pkg::MODE_A_THEN_B && hit_a) begin
          st_d.run = RUN_CAPTURE;
        end
        if (st_q.run == RUN_CAPTURE && bus.valid && bus.opcode_fetch) begin
          store = 1'b1;
        end
      end else begin
        // End trace: store fetches circularly until the trigger arrives.
        if (bus.valid && bus.opcode_fetch) begin
          store = 1'b1;
        end
        if (mode == dtb_pkg::MODE_A_THEN_B && st_q.run == RUN_WAIT_A && hit_a) begin
          st_d.run = RUN_CAPTURE;
        end else if (trig && (mode != dtb_pkg::MODE_A_THEN_B || st_q.run == RUN_CAPTURE)) begin
          run_end = 1'b1;
          st_d.brk = st_q.control[dtb_pkg::CTL_BREAK_ENABLE];
        end
      end
      if (store) begin
        st_d.fifo[st_q.wr_ptr] = store_word;
        st_d.wr_ptr = st_q.wr_ptr + 3'h1;
        if (st_q.count != dtb_pkg::FIFO_FULL_COUNT) begin
          st_d.count = st_q.count + 4'h1;
        end
        if (begin_trace && st_q.count == dtb_pkg::FIFO_FULL_COUNT - 4'h1) begin
          run_end = 1'b1;
          st_d.brk = st_q.control[dtb_pkg::CTL_BREAK_ENABLE];
        end
      end
      if (run_end) begin
        st_d.control[dtb_pkg::CTL_ARM] = 1'b0;
        st_d.run = RUN_IDLE;
        st_d.rd_ptr = st_d.wr_ptr - st_d.count[2:0];
      end
    end
    st_d.brk_tag = st_q.control[dtb_pkg::CTL_TAG];

    // Low-byte read: held while armed, profiling sample while not.
    if (rd_low && !armed) begin
      // The slot just read becomes the tail once the pointer moves on.
      st_d.fifo[st_q.rd_ptr] = st_q.last_opcode;
      st_d.rd_ptr = st_q.rd_ptr + 3'h1;
      st_d.wr_ptr = st_q.rd_ptr + 3'h1;
    end

    if (wr_user) begin
      unique case (acc.addr)
        dtb_pkg::OFF_COMP_A_HIGH: if (!armed) st_d.comp_a_high = acc.wdata;
        dtb_pkg::OFF_COMP_A_LOW: if (!armed) st_d.comp_a_low = acc.wdata;
        dtb_pkg::OFF_COMP_B_HIGH: if (!armed) st_d.comp_b_high = acc.wdata;
        dtb_pkg::OFF_COMP_B_LOW: if (!armed) st_d.comp_b_low = acc.wdata;
        dtb_pkg::OFF_TRIGGER: if (!armed) st_d.trigger = acc.wdata & 8'hcf;
        dtb_pkg::OFF_CONTROL: begin
          if (secure) begin
            wctl[dtb_pkg::CTL_MODULE_ENABLE] = 1'b0;
          end
          if (!wctl[dtb_pkg::CTL_MODULE_ENABLE]) begin
            wctl[dtb_pkg::CTL_ARM] = 1'b0;
          end
          if (wctl[dtb_pkg::CTL_ARM] && !armed) begin
            // A new run clears the flags, the count and the pointers.
            st_d.flag_a = 1'b0;
            st_d.flag_b = 1'b0;
            st_d.count = 4'h0;
            st_d.wr_ptr = 3'h0;
            st_d.rd_ptr = 3'h0;
            st_d.run = RUN_WAIT_A;
            if (mode == dtb_pkg::MODE_EVENT_B) begin
              st_d.run = RUN_CAPTURE;
            end
          end
          if (!wctl[dtb_pkg::CTL_ARM]) begin
            st_d.run = RUN_IDLE;
          end
          st_d.control = wctl;
        end
        dtb_pkg::OFF_FORCE_RESET: begin
          // User writes are dropped; only the background port resets the chip.
          if (acc.from_background) begin
            st_d.force_rst = acc.wdata[dtb_pkg::FORCE_RESET_BIT];
          end
        end
        default: begin
        end
      endcase
    end

    st_d.run_flag = st_d.control[dtb_pkg::CTL_ARM] && st_d.control[dtb_pkg::CTL_MODULE_ENABLE];

    // Read data, registered so it leaves straight from a flip-flop.
    st_d.rdata = 8'h00;
    if (acc.rd) begin
      unique case (acc.addr)
        dtb_pkg::OFF_COMP_A_HIGH: st_d.rdata = st_q.comp_a_high;
        dtb_pkg::OFF_COMP_A_LOW: st_d.rdata = st_q.comp_a_low;
        dtb_pkg::OFF_COMP_B_HIGH: st_d.rdata = st_q.comp_b_high;
        dtb_pkg::OFF_COMP_B_LOW: st_d.rdata = st_q.comp_b_low;
        dtb_pkg::OFF_FIFO_HIGH: begin
          st_d.rdata = event_mode ? 8'h00 : st_q.fifo[st_q.rd_ptr][15:8];
        end
        dtb_pkg::OFF_FIFO_LOW: st_d.rdata = st_q.fifo[st_q.rd_ptr][7:0];
        dtb_pkg::OFF_CONTROL: st_d.rdata = st_q.control;
        dtb_pkg::OFF_TRIGGER: st_d.rdata = st_q.trigger;
        dtb_pkg::OFF_STATUS: st_d.rdata = {st_q.flag_a, st_q.flag_b, armed && enabled,
                                           1'b0, st_q.count};
        dtb_pkg::OFF_FORCE_RESET: st_d.rdata = 8'h00;
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= '0;
      st_q.comp_a_high <= dtb_pkg::RESET_BYTE;
      st_q.control <= dtb_pkg::RESET_BYTE;
      st_q.run <= RUN_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign break_request = st_q.brk;
  assign break_is_tag = st_q.brk_tag;
  assign force_mcu_reset = st_q.force_rst;
  assign run_active_flag = st_q.run_flag;
endmodule
`default_nettype wire

/* hdl/dtb_opcode_track.sv */
// Opcode tracking: passes a match on only when the matched opcode executes.
`timescale 1ns/1ps
`default_nettype none
module dtb_opcode_track (
  input wire logic mclk,
  input wire logic reset,
  input wire logic match_in,
  input wire logic fetch,
  input wire logic executed,
  output logic hit
);
  typedef struct packed {
    logic pending;
  } dtb_track_s;
  dtb_track_s st_q;
  dtb_track_s st_d;
  always_comb begin
    st_d = st_q;
    if (match_in && fetch) begin
      st_d.pending = 1'b1;
    end else if (executed) begin
      st_d.pending = 1'b0;
    end
  end
  assign hit = st_q.pending && executed;
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

/* include/dtb_pkg.sv */
// Package of constants and carrier types for the debug trace and breakpoint registers.
package dtb_pkg;
  // ==========================================================================
  // Register map (byte offsets inside the debug register window)
  // ==========================================================================
  localparam logic [3:0] OFF_COMP_A_HIGH = 4'h0;
  localparam logic [3:0] OFF_COMP_A_LOW = 4'h1;
  localparam logic [3:0] OFF_COMP_B_HIGH = 4'h2;
  localparam logic [3:0] OFF_COMP_B_LOW = 4'h3;
  localparam logic [3:0] OFF_FIFO_HIGH = 4'h4;
  localparam logic [3:0] OFF_FIFO_LOW = 4'h5;
  localparam logic [3:0] OFF_CONTROL = 4'h6;
  localparam logic [3:0] OFF_TRIGGER = 4'h7;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_FORCE_RESET = 4'h9;
  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CTL_MODULE_ENABLE = 7;
  localparam int CTL_ARM = 6;
  localparam int CTL_TAG = 5;
  localparam int CTL_BREAK_ENABLE = 4;
  localparam int CTL_COMP_A_DIR = 3;
  localparam int CTL_COMP_A_DIR_EN = 2;
  localparam int CTL_COMP_B_DIR = 1;
  localparam int CTL_COMP_B_DIR_EN = 0;
  localparam int TRG_QUALIFY_SELECT = 7;
  localparam int TRG_BEGIN = 6;
  localparam int FORCE_RESET_BIT = 0;
  // ==========================================================================
  // Reset values, sizes and trigger modes
  // ==========================================================================
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_FULL_COUNT = 4'h8;
  localparam logic [3:0] MODE_A_ONLY = 4'h0;
  localparam logic [3:0] MODE_A_OR_B = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] MODE_EVENT_B = 4'h3;
  localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
  localparam logic [3:0] MODE_A_AND_B_DATA = 4'h5;
  localparam logic [3:0] MODE_A_NOT_B_DATA = 4'h6;
  localparam logic [3:0] MODE_INSIDE = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE = 4'h8;

  // Register access strobe from the CPU or the serial background port.
  typedef struct packed {
    logic rd;
    logic wr;
    logic from_background;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dtb_access_s;

  // One CPU bus cycle as seen by the comparators.
  typedef struct packed {
    logic valid;
    logic read;
    logic opcode_fetch;
    logic [15:0] addr;
    logic [7:0] data;
  } dtb_bus_s;
endpackage

/* verification/dtb_bg_host.sv */
// Model of the external debug host writing over the serial background channel.
`timescale 1ns/1ps
`default_nettype none
module dtb_bg_host (
  input wire logic mclk,
  output var dtb_pkg::dtb_access_s acc,
  output var logic busy
);
  initial begin
    acc = '0;
    busy = 1'b0;
  end
  // A gap of zero answers promptly; a longer gap stands for a slow serial link.
  task automatic bg_write(input logic [3:0] a, input logic [7:0] d, input int gap);
    repeat (gap + 1) @(posedge mclk);
    #1;
    busy = 1'b1;
    acc = '{rd: 1'b0, wr: 1'b1, from_background: 1'b1, addr: a, wdata: d};
    @(posedge mclk);
    #1;
    busy = 1'b0;
    acc = '{rd: 1'b0, wr: 1'b0, from_background: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

/* verification/dtb_properties.sv */
// Port-level checker for the debug register block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module dtb_properties (
  input wire logic mclk,
  input wire logic reset,
  input wire logic secure,
  input wire dtb_pkg::dtb_access_s acc,
  input wire dtb_pkg::dtb_bus_s bus,
  input wire logic opcode_executed,
  input wire logic [7:0] rdata,
  input wire logic break_request,
  input wire logic break_is_tag,
  input wire logic force_mcu_reset,
  input wire logic run_active_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic wr_frc;
  logic wr_ctl;
  assign wr_frc = acc.wr && acc.addr == dtb_pkg::OFF_FORCE_RESET;
  assign wr_ctl = acc.wr && acc.addr == dtb_pkg::OFF_CONTROL;
  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_user_force_ignored: assert property (
    wr_frc && !acc.from_background |=> !force_mcu_reset)
    else $error("user write raised a reset");
  a_host_force_pulse: assert property (
    wr_frc && acc.from_background && acc.wdata[0] |=> force_mcu_reset)
    else $error("host write gave no reset");
  a_force_reads_zero: assert property (
    acc.rd && acc.addr == dtb_pkg::OFF_FORCE_RESET |=> rdata == 8'h00)
    else $error("force register read not zero");
  a_secure_refuses: assert property (secure && wr_ctl |=> !run_active_flag)
    else $error("enable set while secure");
  a_arm_sets_flag: assert property (
    !secure && wr_ctl && acc.wdata[7:6] == 2'b11 |=> run_active_flag)
    else $error("arm write left flag low");
  a_disarm_stops: assert property (wr_ctl && !acc.wdata[6] |=> !run_active_flag)
    else $error("disarm left flag high");
  a_tag_follows: assert property (
    wr_ctl ##1 (!acc.wr) [*2] |-> break_is_tag == $past(acc.wdata[5], 2))
    else $error("tag select not followed");
  a_break_while_armed: assert property (break_request |-> $past(run_active_flag))
    else $error("break while not armed");
  a_break_ends_run: assert property (break_request |-> ##[0:1] !run_active_flag)
    else $error("run not ended by break");
  a_ctl_readback: assert property (wr_ctl ##1 !acc.wr ##1 (acc.rd && acc.addr == dtb_pkg::OFF_CONTROL)
    |=> rdata[5:0] == $past(acc.wdata[5:0], 3))
    else $error("control readback differs");
  c_break: cover property (break_request);
  c_force: cover property (force_mcu_reset);
  c_run_end: cover property (run_active_flag ##1 !run_active_flag);
endmodule
bind dtb_debug_regs dtb_properties chk_u (.mclk(mclk), .reset(reset), .secure(secure),
  .acc(acc), .bus(bus), .opcode_executed(opcode_executed), .rdata(rdata),
  .break_request(break_request), .break_is_tag(break_is_tag),
  .force_mcu_reset(force_mcu_reset), .run_active_flag(run_active_flag));
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the debug register block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
module tb;
  logic mclk = 1'b0;
  logic reset;
  logic secure = 1'b0;
  logic op_exec = 1'b0;
  logic host_busy;
  logic [7:0] rdata;
  logic break_request, break_is_tag, force_mcu_reset, run_active_flag;
  dtb_pkg::dtb_access_s cpu = '0;
  dtb_pkg::dtb_access_s host_acc;
  dtb_pkg::dtb_access_s acc;
  dtb_pkg::dtb_bus_s bus = '0;
  int err_total = 0;
  int checked = 0;
  int seed = 32'hf429;
  logic [7:0] d, hi, ctl;
  logic [15:0] a16, b16, w;
  logic [15:0] q[$];
  bit seen;
  always #5 mclk = ~mclk;
  assign acc = host_busy ? host_acc : cpu;
  dtb_debug_regs dut_u (.mclk(mclk), .reset(reset), .secure(secure), .acc(acc), .bus(bus),
    .opcode_executed(op_exec), .rdata(rdata), .break_request(break_request),
    .break_is_tag(break_is_tag), .force_mcu_reset(force_mcu_reset),
    .run_active_flag(run_active_flag));
  dtb_bg_host host_u (.mclk(mclk), .acc(host_acc), .busy(host_busy));
  // ==========================================================================
  // Tasks and expectations
  // ==========================================================================
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // An idle edge before each access keeps every strobe to one change per time step.
  task automatic access(input logic r, input logic [3:0] a, input logic [7:0] wd);
    step(1);
    cpu = '{rd: r, wr: !r, from_background: 1'b0, addr: a, wdata: wd};
    step(1);
    d = rdata;
    cpu = '{rd: 1'b0, wr: 1'b0, from_background: 1'b0, addr: ~a, wdata: ~wd};
  endtask
  task automatic bus_cyc(input logic [15:0] a, input logic r, input logic f, input logic [7:0] bd);
    step(1);
    bus = '{valid: 1'b1, read: r, opcode_fetch: f, addr: a, data: bd};
    step(1);
    bus = '{valid: 1'b0, read: !r, opcode_fetch: 1'b0, addr: ~a, data: ~bd};
  endtask
  task automatic wait_break(input int n);
    seen = 0;
    // The pulse may already stand when the call starts, so look before stepping.
    repeat (n) begin
      if (break_request === 1'b1) seen = 1;
      step(1);
    end
  endtask
  task automatic do_reset();
    reset = 1'b1;
    step(8);
    reset = 1'b0;
  endtask
  function automatic logic f_qual(logic en, logic dir, logic rd);
    return !en || (dir == rd);
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    summarize();
  end
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    do_reset();
    for (int i = 0; i < 4; i++) begin
      access(1, i[3:0], 8'h00);
      `CHK(d, 8'h00)
      a16[7:0] = 8'($random(seed));
      access(0, i[3:0], a16[7:0]);
      access(1, i[3:0], 8'h00);
      `CHK(d, a16[7:0])
    end
    access(0, dtb_pkg::OFF_FORCE_RESET, 8'h01);
    `CHK(force_mcu_reset, 1'b0)
    host_u.bg_write(dtb_pkg::OFF_FORCE_RESET, 8'hfe, 0);
    `CHK(force_mcu_reset, 1'b0)
    host_u.bg_write(dtb_pkg::OFF_FORCE_RESET, 8'h01, 3);
    `CHK(force_mcu_reset, 1'b1)
    access(1, dtb_pkg::OFF_FORCE_RESET, 8'h00);
    `CHK(d, 8'h00)
    do_reset();
    // Profiling: eight priming reads, then each read returns an address eight reads old.
    for (int i = 0; i < 16; i++) begin
      a16 = (i == 3) ? 16'hffff : (i == 5 ? 16'h0000 : 16'($random(seed)));
      bus_cyc(a16, 1'b1, 1'b1, 8'h00);
      q.push_back(a16);
      // Writes to either port must leave the stored words alone.
      if (i == 10) access(0, dtb_pkg::OFF_FIFO_LOW, 8'ha5);
      if (i == 10) access(0, dtb_pkg::OFF_FIFO_HIGH, 8'h5a);
      access(1, dtb_pkg::OFF_FIFO_HIGH, 8'h00);
      hi = d;
      access(1, dtb_pkg::OFF_FIFO_HIGH, 8'h00);
      `CHK(d, hi)
      access(1, dtb_pkg::OFF_FIFO_LOW, 8'h00);
      w = q.pop_front();
      if (i >= 8) `CHK({hi, d}, w)
      if (i < 8) q.push_front(w);
    end
    access(0, dtb_pkg::OFF_CONTROL, 8'hc0);
    `CHK(run_active_flag, 1'b1)
    access(0, dtb_pkg::OFF_COMP_A_LOW, 8'h77);
    access(1, dtb_pkg::OFF_COMP_A_LOW, 8'h00);
    `CHK(d, 8'h00)
    access(1, dtb_pkg::OFF_FIFO_LOW, 8'h00);
    hi = d;
    access(1, dtb_pkg::OFF_FIFO_LOW, 8'h00);
    `CHK(d, hi)
    access(0, dtb_pkg::OFF_CONTROL, 8'hea);
    access(1, dtb_pkg::OFF_CONTROL, 8'h00);
    `CHK(d, 8'hea)
    `CHK(break_is_tag, 1'b1)
    access(0, dtb_pkg::OFF_CONTROL, 8'h80);
    `CHK(run_active_flag, 1'b0)
    access(0, dtb_pkg::OFF_CONTROL, 8'h00);
    secure = 1'b1;
    access(0, dtb_pkg::OFF_CONTROL, 8'hc0);
    `CHK(run_active_flag, 1'b0)
    access(1, dtb_pkg::OFF_CONTROL, 8'h00);
    `CHK(d[7], 1'b0)
    secure = 1'b0;
    // Direction qualification on each comparator: wrong direction first, then right one.
    access(0, dtb_pkg::OFF_TRIGGER, 8'h01);
    for (int k = 0; k < 8; k++) begin
      a16 = 16'($random(seed));
      for (int j = 0; j < 4; j++) begin
        b16 = (j[1] == k[2]) ? a16 : ~a16;
        access(0, j[3:0], j[0] ? b16[7:0] : b16[15:8]);
      end
      ctl = 8'hd0 | ({6'h0, k[0], k[1]} << (k[2] ? 0 : 2));
      for (int t = 0; t < 2; t++) begin
        access(0, dtb_pkg::OFF_CONTROL, ctl);
        bus_cyc(a16, k[0] ^ !t[0], 1'b0, 8'h00);
        wait_break(6);
        `CHK(seen, f_qual(k[1], k[0], k[0] ^ !t[0]))
      end
      `CHK(run_active_flag, 1'b0)
    end
    // Tag qualification: a fetch at the B address breaks only once it executes.
    access(0, dtb_pkg::OFF_TRIGGER, 8'h81);
    access(0, dtb_pkg::OFF_CONTROL, 8'hd0);
    bus_cyc(a16, 1'b1, 1'b1, 8'h00);
    wait_break(4);
    `CHK(seen, 1'b0)
    op_exec = 1'b1;
    step(1);
    op_exec = 1'b0;
    wait_break(4);
    `CHK(seen, 1'b1)
    `CHK(run_active_flag, 1'b0)
    // Event-only modes: comparator B hits store bytes until the FIFO is full.
    for (int m = 3; m < 5; m++) begin
      q.delete();
      access(0, dtb_pkg::OFF_TRIGGER, m[7:0]);
      access(0, dtb_pkg::OFF_CONTROL, 8'hd0);
      if (m == 4) bus_cyc(~a16, 1'b1, 1'b0, 8'h00);
      for (int i = 0; i < 8; i++) begin
        d = 8'($random(seed));
        q.push_back({8'h00, d});
        bus_cyc(a16, 1'b0, 1'b0, d);
      end
      wait_break(6);
      `CHK(seen, 1'b1)
      `CHK(run_active_flag, 1'b0)
      for (int i = 0; i < 8; i++) begin
        access(1, dtb_pkg::OFF_FIFO_HIGH, 8'h00);
        `CHK(d, 8'h00)
        access(1, dtb_pkg::OFF_FIFO_LOW, 8'h00);
        w = q.pop_front();
        `CHK(d, w[7:0])
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
